// File: hdl/sdp_pkg.sv
package sdp_pkg;
	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 16;
	localparam int FL_ADDR_W  = 12;
	localparam int NIB_W      = 4;
	localparam int FRAME_BITS = 8;
	localparam int CNT_W      = 5;

	// nibble select codes
	localparam logic [3:0] SEL_DATA0 = 4'h0;
	localparam logic [3:0] SEL_DATA3 = 4'h3;
	localparam logic [3:0] SEL_ADDR0 = 4'h4;
	localparam logic [3:0] SEL_ADDR3 = 4'h7;
	localparam logic [3:0] SEL_CMD   = 4'h8;
	localparam logic [3:0] SEL_MODE  = 4'h9;

	// command codes
	localparam logic [3:0] CMD_PORT_WR    = 4'h0;
	localparam logic [3:0] CMD_FLASH_WR   = 4'h1;
	localparam logic [3:0] CMD_PORT_RD    = 4'h2;
	localparam logic [3:0] CMD_FLASH_RD   = 4'h3;
	localparam logic [3:0] CMD_ACC_RD     = 4'h4;
	localparam logic [3:0] CMD_IP_FL_RD   = 4'h5;
	localparam logic [3:0] CMD_IP_RD      = 4'h6;
	localparam logic [3:0] CMD_HALT       = 4'h7;
	localparam logic [3:0] CMD_START      = 4'h8;
	localparam logic [3:0] CMD_STEP       = 4'h9;
	localparam logic [3:0] CMD_IP_CLR     = 4'hA;
	localparam logic [3:0] CMD_MOD_RST    = 4'hB;
	localparam logic [3:0] CMD_NOP        = 4'hC;
	localparam logic [3:0] CMD_PAGE_ERASE = 4'hD;
	localparam logic [3:0] CMD_PART_ERASE = 4'hE;
	localparam logic [3:0] CMD_AUX_SEL    = 4'hF;

	// interface mode codes
	localparam logic [3:0] MODE_4WIRE = 4'h0;
	localparam logic [3:0] MODE_3WIRE = 4'h1;

	// field positions
	localparam int PORT_MSB = 3;
	localparam int FL_MSB   = 11;
	localparam int PAGE_LSB = 6;

	// reset values
	localparam logic [15:0] DHR_RST  = 16'h0000;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [3:0]  CMD_RST  = 4'hC;
	localparam logic        MODE_RST = 1'b0;

	typedef struct packed {
		logic [3:0] sel;
		logic [3:0] val;
	} sdp_nib_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  sel;
		logic [15:0] wdata;
	} sdp_port_req_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        page_erase;
		logic        part_erase;
		logic        aux;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} sdp_flash_req_t;

	typedef struct packed {
		logic halt;
		logic step;
		logic ip_clear;
		logic mod_reset;
	} sdp_cpu_ctl_t;
endpackage : sdp_pkg

// File: hdl/sdp_sync.sv
module sdp_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_ff;

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			// first stage feeds only the second stage
			always_ff @(posedge clk_sys_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					meta_ff[gi] <= 1'b1;
					q_o[gi]     <= 1'b1;
				end
				else if (ce_i)
				begin
					meta_ff[gi] <= d_i[gi];
					q_o[gi]     <= meta_ff[gi];
				end
			end
		end
	endgenerate
endmodule : sdp_sync

// File: hdl/sdp_link.sv
module sdp_link
	import sdp_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic        sclk_s_i,
	input  wire logic        cs_n_s_i,
	input  wire logic        din_s_i,
	input  wire logic        mode_3w_i,
	input  wire logic [15:0] dhr_i,
	output sdp_nib_t         nib_o,
	output logic             nib_vld_o,
	output logic             dout_o,
	output logic             dout_oe_n_o
);
	logic             sclk_d_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [7:0]       sh_ff;
	logic [15:0]      out_ff;
	logic             arm_ff;
	logic             rise;
	logic             fall;

	assign rise = sclk_s_i & ~sclk_d_ff;
	assign fall = ~sclk_s_i & sclk_d_ff;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sclk_d_ff <= 1'b0;
		else if (ce_i)
			sclk_d_ff <= sclk_s_i;
	end

	// frame: 8 bits lsb first, value nibble then select nibble; extra bits ignored
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_ff    <= '0;
			sh_ff     <= '0;
			nib_o     <= '0;
			nib_vld_o <= 1'b0;
		end
		else if (ce_i)
		begin
			nib_vld_o <= 1'b0;
			if (cs_n_s_i)
				cnt_ff <= '0;
			else if (rise && cnt_ff < CNT_W'(FRAME_BITS))
			begin
				sh_ff  <= {din_s_i, sh_ff[7:1]};
				cnt_ff <= cnt_ff + CNT_W'(1);
				if (cnt_ff == CNT_W'(FRAME_BITS - 1))
				begin
					nib_o     <= {din_s_i, sh_ff[7:1]};
					nib_vld_o <= 1'b1;
				end
			end
		end
	end

	// read-back: holding register snapshot at frame start, shifted out lsb first
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			out_ff      <= '0;
			arm_ff      <= 1'b0;
			dout_o      <= 1'b0;
			dout_oe_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			if (cs_n_s_i)
			begin
				arm_ff      <= 1'b0;
				out_ff      <= dhr_i;
				dout_o      <= dhr_i[0];
				dout_oe_n_o <= 1'b1;
			end
			else
			begin
				// 3-wire shares the pin, so stay off it during the select/value bits
				dout_oe_n_o <= mode_3w_i && cnt_ff < CNT_W'(FRAME_BITS);
				// first fall after the 8th bit only arms; shifting there would lose bit 0
				if (fall && mode_3w_i && cnt_ff >= CNT_W'(FRAME_BITS))
					arm_ff <= 1'b1;
				if (fall && (!mode_3w_i || arm_ff))
				begin
					out_ff <= {1'b0, out_ff[15:1]};
					dout_o <= out_ff[1];
				end
			end
		end
	end
endmodule : sdp_link

// File: hdl/sdp_debug_port.sv
module sdp_debug_port
	import sdp_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        serial_data_input_i,
	output logic             dout_o,
	output logic             dout_oe_n_o,
	output sdp_port_req_t    port_req_o,
	input  wire logic        cpu_port_busy_i,
	input  wire logic [15:0] port_rdata_i,
	output sdp_flash_req_t   flash_req_o,
	input  wire logic        flash_done_i,
	input  wire logic [7:0]  flash_rdata_i,
	output sdp_cpu_ctl_t     cpu_ctl_o,
	input  wire logic [15:0] acc_i,
	input  wire logic [15:0] instruction_pointer_i,
	output logic             mode_3wire_o
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PORT,
		ST_PORT_CAP,
		ST_FLASH
	} sdp_state_t;

	logic        rst_meta_ff;
	logic        rst_n;
	logic [2:0]  pins_s;
	sdp_nib_t    nib;
	logic        nib_vld;
	logic [15:0] data_holding_register_ff;
	logic [15:0] port_flash_address_register_ff;
	logic [3:0]  command_code_register_ff;
	logic        cmd_go_ff;
	sdp_state_t  state_ff;
	logic        port_is_rd_ff;
	logic        dhr_ld;
	logic [15:0] nxt_dhr;

	// reset release through two flops
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	sdp_sync #(
		.W(3)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n),
		.ce_i      (ce_i),
		.d_i       ({sclk_i, cs_n_i, serial_data_input_i}),
		.q_o       (pins_s)
	);

	sdp_link u_link (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.sclk_s_i    (pins_s[2]),
		.cs_n_s_i    (pins_s[1]),
		.din_s_i     (pins_s[0]),
		.mode_3w_i   (mode_3wire_o),
		.dhr_i       (data_holding_register_ff),
		.nib_o       (nib),
		.nib_vld_o   (nib_vld),
		.dout_o      (dout_o),
		.dout_oe_n_o (dout_oe_n_o)
	);

	// command and mode registers
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			command_code_register_ff <= CMD_RST;
			cmd_go_ff                <= 1'b0;
			mode_3wire_o             <= MODE_RST;
		end
		else if (ce_i)
		begin
			cmd_go_ff <= 1'b0;
			if (nib_vld && nib.sel == SEL_CMD)
			begin
				command_code_register_ff <= nib.val;
				cmd_go_ff                <= 1'b1;
			end
			else if (nib_vld && nib.sel == SEL_MODE)
			begin
				if (nib.val == MODE_4WIRE)
					mode_3wire_o <= 1'b0;
				else if (nib.val == MODE_3WIRE)
					mode_3wire_o <= 1'b1;
			end
		end
	end

	// address register, nibble loads
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			port_flash_address_register_ff <= ADDR_RST;
		else if (ce_i && nib_vld && nib.sel >= SEL_ADDR0 && nib.sel <= SEL_ADDR3)
			port_flash_address_register_ff[nib.sel[1:0]*NIB_W +: NIB_W] <= nib.val;
	end

	// holding register results; a result outranks a host nibble in the same cycle
	always_comb
	begin
		dhr_ld  = 1'b0;
		nxt_dhr = data_holding_register_ff;
		if (state_ff == ST_IDLE && cmd_go_ff && cpu_ctl_o.halt)
		begin
			if (command_code_register_ff == CMD_ACC_RD)
			begin
				dhr_ld  = 1'b1;
				nxt_dhr = acc_i;
			end
			else if (command_code_register_ff == CMD_IP_RD)
			begin
				dhr_ld  = 1'b1;
				nxt_dhr = instruction_pointer_i;
			end
		end
		else if (state_ff == ST_PORT_CAP && port_is_rd_ff)
		begin
			dhr_ld  = 1'b1;
			nxt_dhr = port_rdata_i;
		end
		else if (state_ff == ST_FLASH && flash_done_i && flash_req_o.rd)
		begin
			dhr_ld  = 1'b1;
			nxt_dhr = {data_holding_register_ff[15:8], flash_rdata_i};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			data_holding_register_ff <= DHR_RST;
		else if (ce_i)
		begin
			if (dhr_ld)
				data_holding_register_ff <= nxt_dhr;
			else if (nib_vld && nib.sel <= SEL_DATA3)
				data_holding_register_ff[nib.sel[1:0]*NIB_W +: NIB_W] <= nib.val;
		end
	end

	// command execution
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff      <= ST_IDLE;
			port_is_rd_ff <= 1'b0;
			port_req_o    <= '0;
			flash_req_o   <= '0;
			cpu_ctl_o     <= '0;
		end
		else if (ce_i)
		begin
			cpu_ctl_o.step      <= 1'b0;
			cpu_ctl_o.ip_clear  <= 1'b0;
			cpu_ctl_o.mod_reset <= 1'b0;
			case (state_ff)
				ST_IDLE:
				begin
					if (cmd_go_ff)
					begin
						case (command_code_register_ff)
							CMD_PORT_WR, CMD_PORT_RD:
							begin
								// no halt check: ports stay reachable while running
								port_req_o.sel   <= port_flash_address_register_ff[PORT_MSB:0];
								port_req_o.wdata <= data_holding_register_ff;
								port_is_rd_ff    <= command_code_register_ff == CMD_PORT_RD;
								state_ff         <= ST_PORT;
							end
							CMD_HALT:
							begin
								cpu_ctl_o.halt  <= 1'b1;
								flash_req_o.aux <= 1'b0;
							end
							default:
							begin
								// halted-only commands are dropped while running
								if (cpu_ctl_o.halt)
								begin
									case (command_code_register_ff)
										CMD_FLASH_WR:
										begin
											flash_req_o.wr    <= 1'b1;
											flash_req_o.addr  <= port_flash_address_register_ff[FL_MSB:0];
											flash_req_o.wdata <= data_holding_register_ff[7:0];
											state_ff          <= ST_FLASH;
										end
										CMD_FLASH_RD:
										begin
											flash_req_o.rd   <= 1'b1;
											flash_req_o.addr <= port_flash_address_register_ff[FL_MSB:0];
											state_ff         <= ST_FLASH;
										end
										CMD_IP_FL_RD:
										begin
											flash_req_o.rd   <= 1'b1;
											flash_req_o.addr <= instruction_pointer_i[FL_MSB:0];
											state_ff         <= ST_FLASH;
										end
										CMD_START:
											cpu_ctl_o.halt <= 1'b0;
										CMD_STEP:
											cpu_ctl_o.step <= 1'b1;
										CMD_IP_CLR:
											cpu_ctl_o.ip_clear <= 1'b1;
										CMD_MOD_RST:
											cpu_ctl_o.mod_reset <= 1'b1;
										CMD_PAGE_ERASE:
										begin
											flash_req_o.page_erase <= 1'b1;
											flash_req_o.addr <= {port_flash_address_register_ff[FL_MSB:PAGE_LSB],
												6'h00};
											state_ff <= ST_FLASH;
										end
										CMD_PART_ERASE:
										begin
											flash_req_o.part_erase <= 1'b1;
											state_ff               <= ST_FLASH;
										end
										CMD_AUX_SEL:
											flash_req_o.aux <= 1'b1;
										default:
											state_ff <= ST_IDLE;
									endcase
								end
							end
						endcase
					end
				end
				ST_PORT:
				begin
					if (!cpu_port_busy_i)
					begin
						port_req_o.wr <= !port_is_rd_ff;
						port_req_o.rd <= port_is_rd_ff;
						state_ff      <= ST_PORT_CAP;
					end
				end
				ST_PORT_CAP:
				begin
					port_req_o.wr <= 1'b0;
					port_req_o.rd <= 1'b0;
					state_ff      <= ST_IDLE;
				end
				ST_FLASH:
				begin
					if (flash_done_i)
					begin
						flash_req_o.wr         <= 1'b0;
						flash_req_o.rd         <= 1'b0;
						flash_req_o.page_erase <= 1'b0;
						flash_req_o.part_erase <= 1'b0;
						state_ff               <= ST_IDLE;
					end
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule : sdp_debug_port

// File: test/sdp_debug_port_properties.sv
module sdp_debug_port_properties
	import sdp_pkg::*;
(
	input wire logic           clk_sys_i,
	input wire logic           rstn_i,
	input wire logic           cpu_port_busy_i,
	input wire sdp_port_req_t  port_req_o,
	input wire sdp_flash_req_t flash_req_o,
	input wire logic           flash_done_i,
	input wire sdp_cpu_ctl_t   cpu_ctl_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	wire logic fl_op = flash_req_o.wr | flash_req_o.rd | flash_req_o.page_erase
		| flash_req_o.part_erase;

	port_defer_a: assert property (port_req_o.wr || port_req_o.rd |-> !$past(cpu_port_busy_i))
		else $error("serial port access while cpu busy");
	port_pulse_a: assert property (port_req_o.wr |=> !port_req_o.wr)
		else $error("port write longer than one cycle");
	flash_hold_a: assert property (flash_req_o.wr && !flash_done_i |=> flash_req_o.wr)
		else $error("flash write dropped before done");
	flash_halt_a: assert property (fl_op |-> cpu_ctl_o.halt)
		else $error("flash access while cpu runs");
	page_align_a: assert property (flash_req_o.page_erase |-> flash_req_o.addr[5:0] == 6'h00)
		else $error("page erase address not aligned");
	step_once_a: assert property (cpu_ctl_o.step |-> cpu_ctl_o.halt ##1 !cpu_ctl_o.step)
		else $error("step not a single halted cycle");
	ctl_halted_a: assert property (cpu_ctl_o.ip_clear || cpu_ctl_o.mod_reset |-> cpu_ctl_o.halt)
		else $error("pointer clear or module reset while running");
	aux_drop_a: assert property ($rose(cpu_ctl_o.halt) |-> !flash_req_o.aux)
		else $error("halt kept auxiliary partition");
endmodule : sdp_debug_port_properties

bind sdp_debug_port sdp_debug_port_properties i_props (.clk_sys_i, .rstn_i, .cpu_port_busy_i,
	.port_req_o, .flash_req_o, .flash_done_i, .cpu_ctl_o);

// File: test/sdp_host.sv
module sdp_host (
	output logic     sclk_o,
	output logic     cs_n_o,
	output logic     din_o,
	input wire logic dout_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end
	// link clock stands still between frames
	task automatic xfer(input logic [7:0] f, input int n, output logic [15:0] rx);
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			din_o = f[i%8];
			#62.5 sclk_o = 1'b1;
			#62.5 rx[i%16] = dout_i;
			sclk_o = 1'b0;
		end
		#62.5 cs_n_o = 1'b1;
		din_o = ~din_o;
		#400;
	endtask : xfer
endmodule : sdp_host

// File: test/sdp_debug_port_test.sv
module sdp_debug_port_test
	import sdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ACC_V = 16'hA5C3;
	localparam logic [15:0] IP_V  = 16'h0123;
	localparam logic [15:0] PRD_V = 16'h3C96;
	localparam logic [7:0]  FRD_V = 8'h5A;
	logic           clk_sys_i = 1'b0;
	logic           rstn_i = 1'b0;
	logic           busy = 1'b0;
	logic           done = 1'b0;
	logic [15:0]    rx;
	wire logic      sclk, csn, din, dout, oen, m3;
	sdp_port_req_t  preq, last_p;
	sdp_flash_req_t freq, last_f;
	sdp_cpu_ctl_t   ctl;
	int             errors = 0, samples_checked = 0, pcnt = 0, fops = 0, steps = 0, puls = 0;

	always #2.5 clk_sys_i = ~clk_sys_i;
	sdp_host i_host (.sclk_o(sclk), .cs_n_o(csn), .din_o(din), .dout_i(dout));
	sdp_debug_port i_dut (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
		.sclk_i(sclk), .cs_n_i(csn), .serial_data_input_i(din),
		.dout_o(dout), .dout_oe_n_o(oen), .port_req_o(preq),
		.cpu_port_busy_i(busy), .port_rdata_i(PRD_V), .flash_req_o(freq),
		.flash_done_i(done), .flash_rdata_i(FRD_V), .cpu_ctl_o(ctl),
		.acc_i(ACC_V), .instruction_pointer_i(IP_V), .mode_3wire_o(m3)
	);

	// flash answers each op in its first cycle
	always @(posedge clk_sys_i)
	begin
		if (preq.wr || preq.rd)
		begin
			pcnt++;
			last_p = preq;
		end
		if (done)
		begin
			fops++;
			last_f = freq;
		end
		steps += int'(ctl.step);
		puls += int'(ctl.ip_clear) + 4 * int'(ctl.mod_reset);
		#1;
		done = (freq.wr | freq.rd | freq.page_erase | freq.part_erase) & ~done;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic nib(input logic [3:0] s, input logic [3:0] v);
		i_host.xfer({s, v}, 8, rx);
	endtask : nib

	task automatic put16(input logic [3:0] base, input logic [15:0] v);
		for (int i = 0; i < 4; i++)
			nib(base + 4'(i), v[4*i +: 4]);
	endtask : put16

	// unused select 1010 in the first byte leaves every register alone
	task automatic cmd_rd(input logic [3:0] c);
		nib(SEL_CMD, c);
		i_host.xfer(8'hA0, 16, rx);
	endtask : cmd_rd

	task automatic t_port;
		put16(SEL_DATA0, 16'hBEEF);
		put16(SEL_ADDR0, 16'h0005);
		@(posedge clk_sys_i) #1 busy = 1'b1;
		nib(SEL_CMD, CMD_PORT_WR);
		check(16'(pcnt), 16'h0000);
		@(posedge clk_sys_i) #1 busy = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check(16'(pcnt), 16'h0001);
		check(last_p.wdata, 16'hBEEF);
		check(16'(last_p.sel), 16'h0005);
		cmd_rd(CMD_PORT_RD);
		check(rx, PRD_V);
	endtask : t_port

	task automatic t_flash;
		put16(SEL_DATA0, 16'h0077);
		put16(SEL_ADDR0, 16'h0ABC);
		nib(SEL_CMD, CMD_FLASH_WR);
		check(16'(fops), 16'h0000);
		nib(SEL_CMD, CMD_HALT);
		check(16'(ctl.halt), 16'h0001);
		nib(SEL_CMD, CMD_FLASH_WR);
		check({last_f.wr, 3'h0, last_f.addr}, 16'h8ABC);
		check(16'(last_f.wdata), 16'h0077);
		cmd_rd(CMD_FLASH_RD);
		check(rx, {8'h00, FRD_V});
		cmd_rd(CMD_IP_FL_RD);
		check({last_f.rd, 3'h0, last_f.addr}, 16'h8123);
		check(rx, {8'h00, FRD_V});
		nib(SEL_CMD, CMD_PAGE_ERASE);
		check({last_f.page_erase, 3'h0, last_f.addr}, 16'h8A80);
		nib(SEL_CMD, CMD_AUX_SEL);
		check(16'(freq.aux), 16'h0001);
		nib(SEL_CMD, CMD_PART_ERASE);
		check(16'({last_f.part_erase, last_f.aux}), 16'h0003);
		nib(SEL_CMD, CMD_HALT);
		check(16'(freq.aux), 16'h0000);
	endtask : t_flash

	task automatic t_cpu;
		cmd_rd(CMD_ACC_RD); // snapshot taken with the cpu halted
		check(rx, ACC_V);
		cmd_rd(CMD_IP_RD);
		check(rx, IP_V);
		nib(SEL_CMD, CMD_STEP);
		check(16'({steps[3:0], ctl.halt}), 16'h0003);
		nib(SEL_CMD, CMD_IP_CLR);
		check(16'(puls), 16'h0001);
		nib(SEL_CMD, CMD_MOD_RST);
		nib(SEL_CMD, CMD_NOP);
		check(16'(puls), 16'h0005);
		nib(SEL_CMD, CMD_START);
		check(16'(ctl.halt), 16'h0000);
		nib(SEL_CMD, CMD_STEP);
		check(16'(steps), 16'h0001);
	endtask : t_cpu

	task automatic t_mode;
		check({13'h0, m3, ctl.halt, freq.aux}, 16'h0000);
		nib(SEL_MODE, MODE_3WIRE);
		check(16'(m3), 16'h0001);
		put16(SEL_DATA0, 16'h1E2D);
		i_host.xfer(8'hA0, 16, rx);
		check({8'h00, rx[15:8]}, 16'h002D);
		check(16'(oen), 16'h0001);
		nib(SEL_MODE, 4'h6);
		check(16'(m3), 16'h0001);
		nib(SEL_MODE, MODE_4WIRE);
		check(16'(m3), 16'h0000);
	endtask : t_mode

	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial
	begin
		#300us;
		errors++;
		wrap_up;
	end

	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		#1 rstn_i = 1'b1;
		repeat (10) @(posedge clk_sys_i);
		t_mode;
		t_port;
		t_flash;
		t_cpu;
		wrap_up;
	end
endmodule : sdp_debug_port_test
